// ==== design/sfc_pkg.sv ====
/*
 Constants, command codes and types of the serial flash command interpreter.
 Assumes a 50 MHz main clock and an 8N1 UART link to an external programmer.
*/
// Summary of operation
// - Page read returns 256 bytes, lowest first
// - Command 70 returns main then aux status
// - Command 50 clears error bits four, five
// - Erase all needs A7 then confirm D0
// - Lock query returns one byte, fourth slot
// - Command FB returns eight version bytes
// - Command FC dumps one boot page
// - Blank flash accepts every command
// - Unverified ID accepts status, ID, version, baud
// - Speed change byte sent twice, rate switches
// - Characters are 8N1, LSB first
// - Receive timeout sets flag, returns to wait
package sfc_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD_BASE = 9600;
   localparam int BIT_CYC_BASE = CLK_HZ / BAUD_BASE;
   localparam int RX_TIMEOUT_MS = 10;
   localparam int RX_TIMEOUT_CYC = (CLK_HZ / 1000) * RX_TIMEOUT_MS;
   localparam int CNT_W = 16;
   localparam int TMO_W = 24;
   localparam int DATA_BITS = 8;
   localparam logic [3:0] LAST_BIT = 4'h9;
   // Command codes
   localparam logic [7:0] CMD_PAGE_READ = 8'hFF;
   localparam logic [7:0] CMD_PAGE_PROG = 8'h41;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
   localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
   localparam logic [7:0] CMD_READ_STAT = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STAT = 8'h50;
   localparam logic [7:0] CMD_READ_LOCK = 8'h71;
   localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
   localparam logic [7:0] CMD_LOCK_EN = 8'h7A;
   localparam logic [7:0] CMD_LOCK_DIS = 8'h75;
   localparam logic [7:0] CMD_ID_CHECK = 8'hF5;
   localparam logic [7:0] CMD_DOWNLOAD = 8'hFA;
   localparam logic [7:0] CMD_VERSION = 8'hFB;
   localparam logic [7:0] CMD_BOOT_DUMP = 8'hFC;
   localparam logic [7:0] CMD_READ_CHECK = 8'hFD;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [5:0] CMD_BAUD_HI = 6'h2C;
   // Transfer lengths, as last index of the answer
   localparam logic [8:0] LAST_PAGE = 9'h0FF;
   localparam logic [8:0] LAST_STAT = 9'h001;
   localparam logic [8:0] LAST_LOCK = 9'h000;
   localparam logic [8:0] LAST_VER = 9'h007;
   // Memory spaces seen on the read port
   localparam logic [1:0] SPACE_FLASH = 2'h0;
   localparam logic [1:0] SPACE_BOOT = 2'h1;
   localparam logic [1:0] SPACE_LOCK = 2'h2;
   // Status bit positions
   localparam int ERR4_POS = 4;
   localparam int ERR5_POS = 5;
   localparam int TMO_POS = 1;
   localparam int RSV_POS = 0;
   typedef enum logic [3:0] {
      ST_WAIT, ST_ADDR_M, ST_ADDR_H, ST_CONFIRM, ST_BAUD2, ST_FETCH, ST_GAP, ST_LOAD, ST_SEND, ST_HOLD
   } sfc_state_t;
   typedef enum logic [1:0] {SRC_MEM, SRC_STAT, SRC_VER} sfc_src_t;
endpackage

// ==== design/sfc_uart_rx.sv ====
/*
 UART receiver, 8 data bits, LSB first, one stop bit, no parity.
 Assumes rxd_i is asynchronous and idles high; bit period comes from the caller.
*/
`timescale 1ns/100ps
module sfc_uart_rx (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic rxd_i,
   input wire logic [sfc_pkg::CNT_W-1:0] bit_cyc_i,
   output logic [7:0] byte_o,
   output logic valid_o
);
   logic s1_r, s2_r, s3_r, filt_r, busy_r;
   logic [sfc_pkg::CNT_W-1:0] cnt_r;
   logic [3:0] bit_r;
   logic [7:0] shift_r;

   ////////////////////////////////////////////////////////////////////////////
   // Three-stage synchroniser; a level counts once stages two and three agree
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         filt_r <= 1'b1;
      end else begin
         s1_r <= rxd_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            filt_r <= s3_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit sampler; samples mid-bit, drops a frame whose stop bit is low
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_r <= 1'b0;
         cnt_r <= '0;
         bit_r <= '0;
         shift_r <= '0;
         valid_o <= 1'b0;
         byte_o <= '0;
      end else begin
         valid_o <= 1'b0;
         if (!busy_r) begin
            if (!filt_r) begin
               busy_r <= 1'b1;
               cnt_r <= bit_cyc_i >> 1;
               bit_r <= '0;
            end
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
         end else begin
            cnt_r <= bit_cyc_i - 1'b1;
            bit_r <= bit_r + 1'b1;
            if (bit_r == 4'h0 && filt_r) begin
               busy_r <= 1'b0;            // Glitch, not a start bit
            end else if (bit_r == sfc_pkg::LAST_BIT) begin
               busy_r <= 1'b0;
               valid_o <= filt_r;
               byte_o <= shift_r;
            end else if (bit_r != 4'h0) begin
               shift_r <= {filt_r, shift_r[7:1]};
            end
         end
      end
   end

   a_rx_one_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
      valid_o |=> !valid_o) else $error("receive strobe longer than one cycle");
endmodule

// ==== design/sfc_cmd_interp.sv ====
/*
 Serial flash command interpreter: decodes programmer commands from the UART,
 answers with page, status, lock and version bytes, and hands write-type work out.
 Assumes a memory read port answering one cycle after MEM_RD_O, and an executor
 that pulses HANDOFF_DONE_I once it has taken over and finished a handed-out command.
*/
`timescale 1ns/100ps
module sfc_cmd_interp #(
   parameter int BIT_CYC_9600 = sfc_pkg::BIT_CYC_BASE,
   parameter int TMO_CYC = sfc_pkg::RX_TIMEOUT_CYC,
   parameter logic [63:0] VERSION = 64'h5645_5230_3130_3020 // Arbitrary text
) (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic RXD_I,
   input wire logic BLANK_I,
   input wire logic ID_VERIFIED_I,
   input wire logic [7:0] MAIN_STATUS_I,
   input wire logic [7:0] AUX_STATUS_I,
   input wire logic OP_ERR_FOUR_I,
   input wire logic OP_ERR_FIVE_I,
   input wire logic [7:0] MEM_DATA_I,
   input wire logic HANDOFF_DONE_I,
   output logic TXD_O,
   output logic [1:0] BAUD_SEL_O,
   output logic MEM_RD_O,
   output logic [1:0] MEM_SPACE_O,
   output logic [23:0] MEM_ADDR_O,
   output logic EXEC_O,
   output logic [7:0] EXEC_CODE_O,
   output logic [15:0] EXEC_ADDR_O,
   output logic RX_TIMEOUT_O,
   output logic [7:0] RX_BYTE_O,
   output logic RX_VALID_O
);
   sfc_pkg::sfc_state_t state_r;
   sfc_pkg::sfc_src_t src_r;
   logic [7:0] cmd_r, am_r, ah_r, rx_byte, main_stat, aux_stat, load_byte;
   logic [8:0] idx_r, last_r;
   logic [1:0] space_r;
   logic rx_valid, allowed, take, clr_err, tmo_hit, tx_start, tx_busy_r, tx_done_r;
   logic err4_r, err5_r, tmo_r, exec_now;
   logic [sfc_pkg::CNT_W-1:0] bit_cyc, tx_cnt_r;
   logic [sfc_pkg::TMO_W-1:0] tmo_cnt_r;
   logic [9:0] tx_shift_r;
   logic [3:0] tx_bit_r;

   ////////////////////////////////////////////////////////////////////////////
   // Bit period per selected speed; 57600 is a sixth of the base period
   always_comb begin
      case (BAUD_SEL_O)
         2'h0: bit_cyc = sfc_pkg::CNT_W'(BIT_CYC_9600);
         2'h1: bit_cyc = sfc_pkg::CNT_W'(BIT_CYC_9600 / 2);
         2'h2: bit_cyc = sfc_pkg::CNT_W'(BIT_CYC_9600 / 4);
         default: bit_cyc = sfc_pkg::CNT_W'(BIT_CYC_9600 / 6);
      endcase
   end

   sfc_uart_rx u_rx (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .rxd_i(RXD_I),
      .bit_cyc_i(bit_cyc),
      .byte_o(rx_byte),
      .valid_o(rx_valid)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Gate before ID check; blank flash lifts the gate entirely
   assign allowed = BLANK_I || ID_VERIFIED_I || rx_byte == sfc_pkg::CMD_READ_STAT ||
                    rx_byte == sfc_pkg::CMD_ID_CHECK || rx_byte == sfc_pkg::CMD_VERSION ||
                    rx_byte[7:2] == sfc_pkg::CMD_BAUD_HI;
   assign take = state_r == sfc_pkg::ST_WAIT && rx_valid && allowed;
   assign clr_err = take && rx_byte == sfc_pkg::CMD_CLEAR_STAT;
   assign tmo_hit = (state_r == sfc_pkg::ST_ADDR_M || state_r == sfc_pkg::ST_ADDR_H ||
                     state_r == sfc_pkg::ST_CONFIRM || state_r == sfc_pkg::ST_BAUD2) &&
                    !rx_valid && tmo_cnt_r == sfc_pkg::TMO_W'(TMO_CYC - 1);
   assign tx_start = state_r == sfc_pkg::ST_LOAD;
   assign exec_now = (take && (rx_byte == sfc_pkg::CMD_LOCK_EN || rx_byte == sfc_pkg::CMD_LOCK_DIS ||
                               rx_byte == sfc_pkg::CMD_PAGE_PROG || rx_byte == sfc_pkg::CMD_ID_CHECK ||
                               rx_byte == sfc_pkg::CMD_DOWNLOAD || rx_byte == sfc_pkg::CMD_READ_CHECK)) ||
                     (state_r == sfc_pkg::ST_CONFIRM && rx_valid && rx_byte == sfc_pkg::CMD_CONFIRM);

   // Status bytes as sent; the reserved aux bit reads zero
   always_comb begin
      main_stat = MAIN_STATUS_I;
      main_stat[sfc_pkg::ERR4_POS] = err4_r;
      main_stat[sfc_pkg::ERR5_POS] = err5_r;
      aux_stat = AUX_STATUS_I;
      aux_stat[sfc_pkg::TMO_POS] = tmo_r;
      aux_stat[sfc_pkg::RSV_POS] = 1'b0;
      case (src_r)
         sfc_pkg::SRC_MEM: load_byte = MEM_DATA_I;
         sfc_pkg::SRC_STAT: load_byte = (idx_r == '0) ? main_stat : aux_stat;
         default: load_byte = VERSION[8 * (7 - int'(idx_r[2:0])) +: 8];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencer: each byte fills the next slot of the command layout
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state_r <= sfc_pkg::ST_WAIT;
         src_r <= sfc_pkg::SRC_MEM;
         cmd_r <= '0;
         am_r <= '0;
         ah_r <= '0;
         idx_r <= '0;
         last_r <= '0;
         space_r <= sfc_pkg::SPACE_FLASH;
      end else if (tmo_hit) begin
         state_r <= sfc_pkg::ST_WAIT;
      end else begin
         case (state_r)
            sfc_pkg::ST_WAIT: begin
               idx_r <= '0;
               if (take) begin
                  cmd_r <= rx_byte;
                  case (rx_byte)
                     sfc_pkg::CMD_PAGE_READ, sfc_pkg::CMD_BOOT_DUMP, sfc_pkg::CMD_READ_LOCK,
                     sfc_pkg::CMD_BLOCK_ERASE, sfc_pkg::CMD_LOCK_PROG: state_r <= sfc_pkg::ST_ADDR_M;
                     sfc_pkg::CMD_ERASE_ALL: state_r <= sfc_pkg::ST_CONFIRM;
                     sfc_pkg::CMD_READ_STAT: begin
                        src_r <= sfc_pkg::SRC_STAT;
                        last_r <= sfc_pkg::LAST_STAT;
                        state_r <= sfc_pkg::ST_FETCH;
                     end
                     sfc_pkg::CMD_VERSION: begin
                        src_r <= sfc_pkg::SRC_VER;
                        last_r <= sfc_pkg::LAST_VER;
                        state_r <= sfc_pkg::ST_FETCH;
                     end
                     sfc_pkg::CMD_PAGE_PROG, sfc_pkg::CMD_ID_CHECK, sfc_pkg::CMD_DOWNLOAD,
                     sfc_pkg::CMD_READ_CHECK: state_r <= sfc_pkg::ST_HOLD;
                     default: begin
                        if (rx_byte[7:2] == sfc_pkg::CMD_BAUD_HI) begin
                           state_r <= sfc_pkg::ST_BAUD2;
                        end
                     end
                  endcase
               end
            end
            sfc_pkg::ST_ADDR_M: if (rx_valid) begin
               am_r <= rx_byte;
               state_r <= sfc_pkg::ST_ADDR_H;
            end
            sfc_pkg::ST_ADDR_H: if (rx_valid) begin
               ah_r <= rx_byte;
               src_r <= sfc_pkg::SRC_MEM;
               last_r <= (cmd_r == sfc_pkg::CMD_READ_LOCK) ? sfc_pkg::LAST_LOCK : sfc_pkg::LAST_PAGE;
               space_r <= (cmd_r == sfc_pkg::CMD_BOOT_DUMP) ? sfc_pkg::SPACE_BOOT :
                          (cmd_r == sfc_pkg::CMD_READ_LOCK) ? sfc_pkg::SPACE_LOCK : sfc_pkg::SPACE_FLASH;
               if (cmd_r == sfc_pkg::CMD_BLOCK_ERASE || cmd_r == sfc_pkg::CMD_LOCK_PROG) begin
                  state_r <= sfc_pkg::ST_CONFIRM;
               end else begin
                  state_r <= sfc_pkg::ST_FETCH;
               end
            end
            sfc_pkg::ST_CONFIRM, sfc_pkg::ST_BAUD2: if (rx_valid) begin
               state_r <= sfc_pkg::ST_WAIT;          // Wrong confirm byte drops the frame
            end
            sfc_pkg::ST_FETCH: state_r <= sfc_pkg::ST_GAP;
            sfc_pkg::ST_GAP: state_r <= sfc_pkg::ST_LOAD;
            sfc_pkg::ST_LOAD: state_r <= sfc_pkg::ST_SEND;
            sfc_pkg::ST_SEND: if (tx_done_r) begin
               idx_r <= idx_r + 1'b1;
               state_r <= (idx_r == last_r) ? sfc_pkg::ST_WAIT : sfc_pkg::ST_FETCH;
            end
            sfc_pkg::ST_HOLD: if (HANDOFF_DONE_I) begin
               state_r <= sfc_pkg::ST_WAIT;
            end
            default: state_r <= sfc_pkg::ST_WAIT;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory read port, address walks upward from the page base
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         MEM_RD_O <= 1'b0;
         MEM_ADDR_O <= '0;
         MEM_SPACE_O <= sfc_pkg::SPACE_FLASH;
      end else begin
         MEM_RD_O <= state_r == sfc_pkg::ST_FETCH && src_r == sfc_pkg::SRC_MEM;
         if (state_r == sfc_pkg::ST_FETCH) begin
            MEM_ADDR_O <= {ah_r, am_r, idx_r[7:0]};
            MEM_SPACE_O <= space_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hand-out strobe for commands whose work lives elsewhere
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         EXEC_O <= 1'b0;
         EXEC_CODE_O <= '0;
         EXEC_ADDR_O <= '0;
      end else begin
         EXEC_O <= exec_now;
         if (exec_now) begin
            EXEC_CODE_O <= (state_r == sfc_pkg::ST_CONFIRM) ? cmd_r : rx_byte;
            EXEC_ADDR_O <= {ah_r, am_r};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status flags; a set in the clearing cycle wins
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         err4_r <= 1'b0;
         err5_r <= 1'b0;
         tmo_r <= 1'b0;
         RX_TIMEOUT_O <= 1'b0;
      end else begin
         err4_r <= OP_ERR_FOUR_I || (err4_r && !clr_err);
         err5_r <= OP_ERR_FIVE_I || (err5_r && !clr_err);
         tmo_r <= tmo_r || tmo_hit;
         RX_TIMEOUT_O <= tmo_r || tmo_hit;
      end
   end

   // Inter-byte timer, restarted by every received byte
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tmo_cnt_r <= '0;
      end else if (rx_valid || state_r == sfc_pkg::ST_WAIT || tmo_hit) begin
         tmo_cnt_r <= '0;
      end else begin
         tmo_cnt_r <= tmo_cnt_r + 1'b1;
      end
   end

   // Speed changes only when the same speed byte arrives twice
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         BAUD_SEL_O <= '0;
      end else if (state_r == sfc_pkg::ST_BAUD2 && rx_valid && rx_byte == cmd_r) begin
         BAUD_SEL_O <= cmd_r[1:0];
      end
   end

   // Received bytes passed on, for the executor of handed-out commands
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         RX_BYTE_O <= '0;
         RX_VALID_O <= 1'b0;
      end else begin
         RX_VALID_O <= rx_valid;
         RX_BYTE_O <= rx_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter: start bit, eight data bits LSB first, one stop bit
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         TXD_O <= 1'b1;
         tx_busy_r <= 1'b0;
         tx_done_r <= 1'b0;
         tx_shift_r <= '1;
         tx_bit_r <= '0;
         tx_cnt_r <= '0;
      end else begin
         tx_done_r <= 1'b0;
         if (!tx_busy_r) begin
            if (tx_start) begin
               tx_shift_r <= {1'b1, load_byte, 1'b0};
               tx_busy_r <= 1'b1;
               tx_bit_r <= '0;
               tx_cnt_r <= bit_cyc - 1'b1;
               TXD_O <= 1'b0;
            end
         end else if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
         end else if (tx_bit_r == sfc_pkg::LAST_BIT) begin
            tx_busy_r <= 1'b0;
            tx_done_r <= 1'b1;
         end else begin
            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
            TXD_O <= tx_shift_r[1];
            tx_bit_r <= tx_bit_r + 1'b1;
            tx_cnt_r <= bit_cyc - 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   a_page_low_first: assert property ((state_r == sfc_pkg::ST_ADDR_H && rx_valid &&
      cmd_r == sfc_pkg::CMD_PAGE_READ) |=> ##1 (MEM_RD_O && MEM_ADDR_O[7:0] == 8'h00 &&
      MEM_ADDR_O[23:16] == ah_r)) else $error("page read not started at page base");
   a_stat_main_first: assert property ((tx_start && src_r == sfc_pkg::SRC_STAT && idx_r == '0)
      |=> tx_shift_r[8:1] == $past(main_stat)) else $error("status answer not main byte first");
   a_err_cleared: assert property ((clr_err && !OP_ERR_FOUR_I && !OP_ERR_FIVE_I)
      |=> !err4_r && !err5_r) else $error("error bits survived clear command");
   a_erase_confirm: assert property ((EXEC_O && EXEC_CODE_O == sfc_pkg::CMD_ERASE_ALL)
      |-> $past(rx_valid) && $past(rx_byte) == sfc_pkg::CMD_CONFIRM) else $error("erase without confirm");
   a_lock_single: assert property ((tx_done_r && src_r == sfc_pkg::SRC_MEM &&
      MEM_SPACE_O == sfc_pkg::SPACE_LOCK && state_r == sfc_pkg::ST_SEND) |=> state_r == sfc_pkg::ST_WAIT)
      else $error("lock answer longer than one byte");
   a_ver_continues: assert property ((tx_done_r && state_r == sfc_pkg::ST_SEND &&
      src_r == sfc_pkg::SRC_VER && idx_r != sfc_pkg::LAST_VER) |=> state_r == sfc_pkg::ST_FETCH)
      else $error("version answer cut short");
   a_reject_locked: assert property ((state_r == sfc_pkg::ST_WAIT && rx_valid && !allowed)
      |=> state_r == sfc_pkg::ST_WAIT && !EXEC_O) else $error("command accepted before ID check");
   a_baud_twice: assert property (!$stable(BAUD_SEL_O) |-> $past(state_r) == sfc_pkg::ST_BAUD2 &&
      $past(rx_byte) == $past(cmd_r)) else $error("speed changed without repeated byte");
   a_timeout_flag: assert property (tmo_hit |=> state_r == sfc_pkg::ST_WAIT && RX_TIMEOUT_O)
      else $error("timeout did not abort frame");
   a_tx_stop_high: assert property (tx_done_r |-> TXD_O) else $error("stop bit not high");

   c_page_read: cover property (state_r == sfc_pkg::ST_SEND && idx_r == sfc_pkg::LAST_PAGE);
   c_status_read: cover property (tx_done_r && src_r == sfc_pkg::SRC_STAT && idx_r == sfc_pkg::LAST_STAT);
   c_erase_all: cover property (EXEC_O && EXEC_CODE_O == sfc_pkg::CMD_ERASE_ALL);
   c_timeout: cover property (tmo_hit);
endmodule

// ==== sim/sfc_prog_model.sv ====
/*
 Behavioural model of the serial programmer: sends 8N1 characters, collects answers.
 Assumes the bench sets bit_cyc to the period in clock cycles of the current speed.
*/
`timescale 1ns/100ps
module sfc_prog_model (
   input wire logic clk_i,
   input wire logic txd_i,
   output logic rxd_o
);
   int bit_cyc = 12;
   logic [7:0] got_q[$];
   initial rxd_o = 1'b1;
   ////////////////////////////////////////////////////////////
   // Start bit, eight bits LSB first, one stop bit, no parity
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i);
         rxd_o <= f[i];
         repeat (bit_cyc - 1) @(posedge clk_i);
      end
   endtask
   ////////////////////////////////////////////////////////////
   // Sample answers mid-bit; a low stop bit spoils the byte so it cannot match
   always begin : rx_loop
      logic [7:0] b;
      @(negedge txd_i);
      repeat (bit_cyc / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc) @(posedge clk_i);
         b[i] = txd_i;
      end
      repeat (bit_cyc) @(posedge clk_i);
      got_q.push_back(txd_i ? b : 8'hXX);
   end
endmodule

// ==== sim/testbench.sv ====
/*
 Self-checking bench of the command interpreter with a programmer model.
 Assumes short sim counts: 12 cycles a bit at 9600, 200 cycles of receive timeout.
*/
`timescale 1ns/100ps
module testbench;
   localparam logic [63:0] VER = 64'h1122_3344_5566_7788; // Arbitrary text
   logic clk, rstn, rxd, blank, idv, e4, e5, done, txd, rd, ex, tmo, rxv;
   logic [7:0] mst, ast, mdat, ecode, rxb;
   logic [1:0] bsel, spc;
   logic [23:0] addr;
   logic [15:0] eaddr;
   int n_errors = 0, tests_run = 0, cyc = 0, n_ex = 0, n_rd = 0;
   logic [7:0] last_rx = 8'h00;
   sfc_cmd_interp #(.BIT_CYC_9600(12), .TMO_CYC(200), .VERSION(VER)) i_dut (.CLK_I(clk), .RESETN_I(rstn),
      .RXD_I(rxd), .BLANK_I(blank), .ID_VERIFIED_I(idv), .MAIN_STATUS_I(mst), .AUX_STATUS_I(ast),
      .OP_ERR_FOUR_I(e4), .OP_ERR_FIVE_I(e5), .MEM_DATA_I(mdat), .HANDOFF_DONE_I(done), .TXD_O(txd),
      .BAUD_SEL_O(bsel), .MEM_RD_O(rd), .MEM_SPACE_O(spc), .MEM_ADDR_O(addr), .EXEC_O(ex),
      .EXEC_CODE_O(ecode), .EXEC_ADDR_O(eaddr), .RX_TIMEOUT_O(tmo), .RX_BYTE_O(rxb), .RX_VALID_O(rxv));
   sfc_prog_model i_prog (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
   ////////////////////////////////////////////////////////////
   // Memory answers from address and space, so a wrong slot shows
   assign mdat = addr[7:0] ^ addr[15:8] ^ addr[23:16] ^ {spc, 6'h00};
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Count hand-outs; cut a hang short well past the expected run length
   always @(posedge clk) begin
      cyc++;
      if (ex === 1'b1) n_ex++;
      if (rd === 1'b1) n_rd++;
      if (rxv === 1'b1) last_rx = rxb; // Echo of every byte, kept for the hold test
      if (cyc == 95000) begin
         n_errors++;
         final_report;
      end
   end
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic get(output logic [7:0] b);
      while (i_prog.got_q.size() == 0) @(posedge clk);
      b = i_prog.got_q.pop_front();
   endtask
   // Read status and compare both answer bytes
   task automatic status(input logic [7:0] m, input logic [7:0] a);
      logic [7:0] b;
      i_prog.send(8'h70);
      get(b);
      check("main", m, b);
      get(b);
      check("aux", a, b);
   endtask
   // No answer may appear in a generous quiet window
   task automatic silent(input string what);
      repeat (30 * i_prog.bit_cyc) @(posedge clk);
      check(what, 0, i_prog.got_q.size());
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_locked;
      logic [7:0] b;
      status(8'hCF, 8'h58);
      i_prog.send(8'hFF);
      i_prog.send(8'h01);
      i_prog.send(8'h02);
      silent("refused");
      blank <= 1'b1;
      i_prog.send(8'h71);
      i_prog.send(8'h05);
      i_prog.send(8'h06);
      get(b);
      check("lock", 8'h83, b);
      silent("lock one byte");
      blank <= 1'b0;
      $display("Test locked done");
   endtask
   task automatic t_errclr;
      idv <= 1'b1;
      e4 <= 1'b1;
      e5 <= 1'b1;
      @(posedge clk);
      e4 <= 1'b0;
      e5 <= 1'b0;
      status(8'hFF, 8'h58);
      i_prog.send(8'h50);
      status(8'hCF, 8'h58);
      i_prog.send(8'h12);
      silent("unknown");
      $display("Test clear done");
   endtask
   task automatic t_page(input logic [7:0] cmd, input logic [1:0] s);
      logic [7:0] b;
      int r0;
      r0 = n_rd;
      i_prog.send(cmd);
      i_prog.send(8'h34);
      i_prog.send(8'h12);
      for (int i = 0; i < 256; i++) begin
         get(b);
         check("page", i[7:0] ^ 8'h26 ^ {s, 6'h00}, b);
      end
      silent("page end");
      check("reads", r0 + 256, n_rd);
      $display("Test page %h done", cmd);
   endtask
   task automatic t_misc;
      logic [7:0] b;
      i_prog.send(8'hFB);
      for (int i = 7; i >= 0; i--) begin
         get(b);
         check("version", VER[i*8+:8], b);
      end
      // The byte is taken a few cycles after the stop bit ends, so wait before judging
      i_prog.send(8'hA7);
      i_prog.send(8'h55);
      repeat (16) @(posedge clk);
      check("no erase", 0, n_ex);
      i_prog.send(8'hA7);
      i_prog.send(8'hD0);
      repeat (16) @(posedge clk);
      check("erase", 1, n_ex);
      check("code", 8'hA7, ecode);
      i_prog.send(8'hB1);
      i_prog.send(8'hB1);
      repeat (16) @(posedge clk);
      check("speed", 1, bsel);
      i_prog.bit_cyc = 6;
      status(8'hCF, 8'h58);
      i_prog.send(8'hB0);
      i_prog.send(8'hB0);
      repeat (16) @(posedge clk);
      check("speed back", 0, bsel);
      i_prog.bit_cyc = 12;
      i_prog.send(8'hFF);
      repeat (230) @(posedge clk);
      check("timeout", 1, tmo);
      status(8'hCF, 8'h5A);
      $display("Test misc done");
   endtask
   // Hand-out commands: confirmed erase, hold until done, echo, fresh status sources
   task automatic t_exec;
      i_prog.send(8'h20);
      i_prog.send(8'h56);
      i_prog.send(8'h78);
      i_prog.send(8'hD0);
      repeat (16) @(posedge clk);
      check("blk erase", 2, n_ex);
      check("blk code", 8'h20, ecode);
      check("blk addr", 16'h7856, eaddr);
      i_prog.send(8'h41);
      i_prog.send(8'h70);
      silent("hold");
      check("echo", 8'h70, last_rx);
      check("prog", 3, n_ex);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      mst <= 8'h30;
      ast <= 8'hA4;
      status(8'h00, 8'hA6);
      $display("Test exec done");
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      {blank, idv, e4, e5, done} = 5'h00;
      mst = 8'hCF;
      ast = 8'h5B;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_locked;
      t_errclr;
      t_page(8'hFF, 2'h0);
      t_page(8'hFC, 2'h1);
      t_misc;
      t_exec;
      final_report;
   end
endmodule
